// File: pkg/hrxf_pkg.sv
// Constants for the HDLC receive FIFO readout block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package hrxf_pkg;
  // Register byte addresses
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  ADDR_LIVE    = 8'hA0;
  localparam logic [7:0]  ADDR_PEEK    = 8'hAC;
  localparam logic [7:0]  ADDR_CTRL    = 8'hB0;
  localparam logic [7:0]  ADDR_LATCH   = 8'hB4;
  localparam logic [7:0]  ADDR_IEN     = 8'hB8;
  localparam logic [7:0]  ADDR_READOUT = 8'hBC;
  // Event and live status bit positions
  localparam int          BIT_AVAIL    = 0;
  localparam int          BIT_EMPTY    = 1;
  localparam int          BIT_FULL     = 2;
  localparam int          BIT_START    = 3;
  localparam logic [15:0] EVENT_MASK   = 16'h000D;
  // Control register fields
  localparam int          CTRL_REORDER = 3;
  localparam int          CTRL_LEVEL   = 8;
  localparam int          LEVEL_W      = 5;
  localparam logic [15:0] CTRL_RESET   = 16'h0800;
  localparam logic [15:0] CTRL_MASK    = 16'h1F08;
  localparam int          GROUP_SHIFT  = 3;
  // Readout register fields
  localparam int          DATA_POS     = 8;
  localparam int          STAT_POS     = 1;
  localparam int          VALID_POS    = 0;
  localparam int          STAT_W       = 3;
  localparam int          BYTE_W       = 8;
  localparam int          FIFO_DEPTH   = 256;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    HRXF_MIDDLE    = 3'h0,
    HRXF_START     = 3'h1,
    HRXF_RSVD_2    = 3'h2,
    HRXF_RSVD_3    = 3'h3,
    HRXF_END_GOOD  = 3'h4,
    HRXF_END_FCS   = 3'h5,
    HRXF_END_BAD   = 3'h6,
    HRXF_END_ABORT = 3'h7
  } hrxf_status_e;
endpackage

// File: pkg/hrxf_fifo_if.sv
// Carrier between the readout logic and the FIFO store.
// Assumes both ends share one clock.
interface hrxf_fifo_if #(
  parameter int DW = 11,
  parameter int CW = 9
);
  logic          wr_valid;
  logic          wr_ready;
  logic [DW-1:0] wr_data;
  logic          rd_pop;
  logic [DW-1:0] rd_data;
  logic          rd_avail;
  logic [CW-1:0] count;
  logic          full;

  modport store (
    input  wr_valid, wr_data, rd_pop,
    output wr_ready, rd_data, rd_avail, count, full
  );
  modport user (
    output wr_valid, wr_data, rd_pop,
    input  wr_ready, rd_data, rd_avail, count, full
  );
endinterface

// File: core/hrxf_fifo.sv
// Receive FIFO store: entries of packet status plus data byte.
// Pops from the user while rd_avail is low are ignored.
module hrxf_fifo #(
  parameter int DEPTH = 256,
  parameter int DW    = 11,
  parameter int CW    = 9
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Both sides
  hrxf_fifo_if.store      fif
);
  localparam int AW = $clog2(DEPTH);

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  wire           do_wr;
  wire           do_rd;

  assign fif.full     = (count_q == CW'(DEPTH));
  assign fif.wr_ready = !fif.full;
  assign fif.rd_avail = (count_q != '0);
  assign fif.rd_data  = mem[rd_ptr_q];
  assign fif.count    = count_q;
  assign do_wr        = fif.wr_valid && fif.wr_ready;
  // Pop on empty is ignored, pointers stay put
  assign do_rd        = fif.rd_pop && fif.rd_avail; // R16
  assign count_d      = count_q + CW'(do_wr) - CW'(do_rd);

  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr_q] <= fif.wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + AW'(do_wr);
      rd_ptr_q <= rd_ptr_q + AW'(do_rd); // R4
      count_q  <= count_d;
    end
  end
endmodule

// File: core/hrxf_readout.sv
// HDLC receive FIFO readout with AXI4-Lite registers and event interrupt.
// Assumes the receiver writes entries on CLK and the global port
// interrupt enable arrives as a level on CLK.
//
// Summary of operation
// R1: Start interrupt needs latch, enable, global enable.
// R2: Full interrupt needs latch, enable, global enable.
// R3: Available interrupt needs latch, enable, global enable.
// R4: Upper byte read advances to next entry.
// R5: Lower byte shows status of next data.
// R6: Host checks valid before reading data byte.
// R7: Data in bits 15:8, reorder picks order.
// R8: Status bits 3:1, middle 000, start 001.
// R9: End codes 100 good to 111 aborted.
// R10: Bit 0 high only when byte valid.
// R11: Start latch sets on start entry write.
// R12: Full latch sets on full rising edge.
// R13: Available latch sets on available rising edge.
// R14: Available when count reaches level times eight.
// R15: Bits 7:4 zero, valid zero after reset.
// R16: Empty read leaves FIFO untouched.
module hrxf_readout #(
  parameter int DEPTH = hrxf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AXI4-Lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // AXI4-Lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Receiver write side
  input  wire logic        RX_WR_VALID,
  input  wire logic [7:0]  RX_WR_BYTE,
  input  wire logic [2:0]  RX_WR_STATUS,
  output logic             RX_WR_READY,
  // Interrupt
  input  wire logic        PORT_IRQ_ENABLE,
  output logic             IRQ
);
  localparam int DW = hrxf_pkg::STAT_W + hrxf_pkg::BYTE_W;
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int LB_W = hrxf_pkg::LEVEL_W + hrxf_pkg::GROUP_SHIFT;

  // Reverse bit order of a byte
  function automatic logic [7:0] reverse_byte(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // Apply byte strobes to a 16-bit register
  function automatic logic [15:0] strobe16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0]  st
  );
    logic [15:0] r;
    r = old;
    if (st[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (st[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  hrxf_fifo_if #(.DW(DW), .CW(CW)) fif ();

  hrxf_fifo #(
    .DEPTH (DEPTH),
    .DW    (DW),
    .CW    (CW)
  ) u_fifo (
    .clk   (CLK),
    .rst_n (RST_N),
    .fif   (fif.store)
  );

  // Registers
  logic [15:0] ctrl_q;
  logic [15:0] ien_q;
  logic [15:0] latch_q;
  logic [15:0] latch_d;
  logic        full_prev_q;
  logic        avail_prev_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Receiver side
  wire         wr_take;
  wire         start_evt;
  wire         full_live;
  wire         avail_live;
  wire         full_evt;
  wire         avail_evt;
  wire [LB_W-1:0] level_bytes;
  wire [hrxf_pkg::LEVEL_W-1:0] level;

  assign fif.wr_valid = RX_WR_VALID;
  assign fif.wr_data  = {RX_WR_STATUS, RX_WR_BYTE};
  assign RX_WR_READY  = fif.wr_ready;
  assign wr_take      = RX_WR_VALID && fif.wr_ready;
  assign start_evt    = wr_take
                      && (RX_WR_STATUS == hrxf_pkg::HRXF_START); // R11
  assign level        = ctrl_q[hrxf_pkg::CTRL_LEVEL +: hrxf_pkg::LEVEL_W];
  assign level_bytes  = LB_W'(level) << hrxf_pkg::GROUP_SHIFT;
  // Wide compare: the level may exceed what a small store can count
  assign avail_live   = (32'(fif.count) >= 32'(level_bytes)); // R14
  assign full_live    = fif.full;
  assign full_evt     = full_live && !full_prev_q; // R12
  assign avail_evt    = avail_live && !avail_prev_q; // R13

  // Presented entry
  wire [7:0]   raw_byte;
  wire [2:0]   raw_stat;
  wire         entry_valid;
  wire [7:0]   shown_byte;
  wire [2:0]   shown_stat;
  wire [15:0]  readout_word;

  assign raw_byte     = fif.rd_data[7:0];
  assign raw_stat     = fif.rd_data[10:8];
  assign entry_valid  = fif.rd_avail; // R10
  // First received bit sits in bit 0 unless reordered to bit 7
  assign shown_byte   = !entry_valid ? 8'h00
                      : ctrl_q[hrxf_pkg::CTRL_REORDER] ? reverse_byte(raw_byte)
                      : raw_byte; // R7
  assign shown_stat   = entry_valid ? raw_stat : 3'h0; // R8 R9
  // Status and valid belong to the byte returned with them
  assign readout_word = {shown_byte, 4'h0, shown_stat, entry_valid}; // R5 R15

  // Read channel decode
  wire         rd_take;
  wire         rd_hit_readout;
  wire         rd_mapped;
  wire [31:0]  rd_mux;
  wire [15:0]  live_word;

  assign live_word = (16'(avail_live) << hrxf_pkg::BIT_AVAIL)
                   | (16'(!fif.rd_avail) << hrxf_pkg::BIT_EMPTY)
                   | (16'(full_live) << hrxf_pkg::BIT_FULL);
  assign ARREADY        = !rvalid_q;
  assign rd_take        = ARVALID && !rvalid_q;
  assign rd_hit_readout = (ARADDR[7:2] == hrxf_pkg::ADDR_READOUT[7:2]);
  assign rd_mapped      = rd_hit_readout
                        || (ARADDR[7:2] == hrxf_pkg::ADDR_PEEK[7:2])
                        || (ARADDR[7:2] == hrxf_pkg::ADDR_LIVE[7:2])
                        || (ARADDR[7:2] == hrxf_pkg::ADDR_CTRL[7:2])
                        || (ARADDR[7:2] == hrxf_pkg::ADDR_LATCH[7:2])
                        || (ARADDR[7:2] == hrxf_pkg::ADDR_IEN[7:2]);
  assign rd_mux =
      (rd_hit_readout
       || ARADDR[7:2] == hrxf_pkg::ADDR_PEEK[7:2]) ? {16'h0000, readout_word}
    : (ARADDR[7:2] == hrxf_pkg::ADDR_LIVE[7:2])  ? {16'h0000, live_word}
    : (ARADDR[7:2] == hrxf_pkg::ADDR_CTRL[7:2])  ? {16'h0000, ctrl_q}
    : (ARADDR[7:2] == hrxf_pkg::ADDR_LATCH[7:2]) ? {16'h0000, latch_q}
    : (ARADDR[7:2] == hrxf_pkg::ADDR_IEN[7:2])   ? {16'h0000, ien_q}
    : 32'h0000_0000;
  // Every data read requests a pop; the store ignores it when no entry is valid
  assign fif.rd_pop = rd_take && rd_hit_readout; // R4 R16

  // Write channel
  wire         wr_do;
  wire [7:0]   wr_addr;
  wire         wr_mapped;
  wire         wr_ctrl;
  wire         wr_latch;
  wire         wr_ien;
  wire [15:0]  w1c_bits;

  assign AWREADY   = !aw_held_q && !bvalid_q;
  assign WREADY    = !w_held_q && !bvalid_q;
  assign wr_do     = aw_held_q && w_held_q && !bvalid_q;
  assign wr_addr   = awaddr_q;
  assign wr_ctrl   = wr_do && (wr_addr[7:2] == hrxf_pkg::ADDR_CTRL[7:2]);
  assign wr_latch  = wr_do && (wr_addr[7:2] == hrxf_pkg::ADDR_LATCH[7:2]);
  assign wr_ien    = wr_do && (wr_addr[7:2] == hrxf_pkg::ADDR_IEN[7:2]);
  assign wr_mapped = (wr_addr[7:2] == hrxf_pkg::ADDR_CTRL[7:2])
                   || (wr_addr[7:2] == hrxf_pkg::ADDR_LATCH[7:2])
                   || (wr_addr[7:2] == hrxf_pkg::ADDR_IEN[7:2])
                   || (wr_addr[7:2] == hrxf_pkg::ADDR_READOUT[7:2])
                   || (wr_addr[7:2] == hrxf_pkg::ADDR_PEEK[7:2])
                   || (wr_addr[7:2] == hrxf_pkg::ADDR_LIVE[7:2]);
  assign w1c_bits  = wr_latch ? strobe16(16'h0000, wdata_q, wstrb_q) : 16'h0000;

  // Sticky events: a new event wins over a same-cycle clear
  wire [15:0]  evt_bits;
  assign evt_bits = (16'(avail_evt) << hrxf_pkg::BIT_AVAIL)
                  | (16'(full_evt) << hrxf_pkg::BIT_FULL)
                  | (16'(start_evt) << hrxf_pkg::BIT_START);
  assign latch_d = ((latch_q & ~w1c_bits) | evt_bits) & hrxf_pkg::EVENT_MASK;

  // Interrupt gated per source and by the port enable
  assign IRQ = PORT_IRQ_ENABLE
             && ((latch_q[hrxf_pkg::BIT_START] && ien_q[hrxf_pkg::BIT_START]) // R1
              || (latch_q[hrxf_pkg::BIT_FULL] && ien_q[hrxf_pkg::BIT_FULL]) // R2
              || (latch_q[hrxf_pkg::BIT_AVAIL] && ien_q[hrxf_pkg::BIT_AVAIL])); // R3

  assign BVALID = bvalid_q;
  assign BRESP  = bresp_q;
  assign RVALID = rvalid_q;
  assign RDATA  = rdata_q;
  assign RRESP  = rresp_q;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_q       <= hrxf_pkg::CTRL_RESET;
      ien_q        <= 16'h0000;
      latch_q      <= 16'h0000;
      full_prev_q  <= 1'b0;
      avail_prev_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= strobe16(ctrl_q, wdata_q, wstrb_q) & hrxf_pkg::CTRL_MASK;
      end
      if (wr_ien)
      begin
        ien_q <= strobe16(ien_q, wdata_q, wstrb_q) & hrxf_pkg::EVENT_MASK;
      end
      latch_q      <= latch_d;
      full_prev_q  <= full_live;
      avail_prev_q <= avail_live;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= hrxf_pkg::RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
      end
      if (wr_do)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped ? hrxf_pkg::RESP_OKAY : hrxf_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && BREADY)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= hrxf_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_mapped ? hrxf_pkg::RESP_OKAY : hrxf_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && RREADY)
    begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// File: sim/hrxf_readout_props.sv
// Port-level checks for the receive FIFO readout block.
// Assumes a bind to hrxf_readout on its single clock.
module hrxf_readout_props (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [7:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // Receiver and interrupt
  input wire logic        RX_WR_READY,
  input wire logic        PORT_IRQ_ENABLE,
  input wire logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  logic live_q;
  wire logic mapped = ARADDR inside {hrxf_pkg::ADDR_LIVE, hrxf_pkg::ADDR_PEEK,
    hrxf_pkg::ADDR_CTRL, hrxf_pkg::ADDR_LATCH, hrxf_pkg::ADDR_IEN, hrxf_pkg::ADDR_READOUT};

  // Remembers whether the answer in flight is the live status word
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      live_q <= 1'b0;
    else if (ARVALID && ARREADY)
      live_q <= (ARADDR == hrxf_pkg::ADDR_LIVE);

  sequence s_rd;
    ARVALID && ARREADY;
  endsequence
  sequence s_rd_pop;
    s_rd ##0 ARADDR == hrxf_pkg::ADDR_READOUT;
  endsequence
  sequence s_wr_both;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence

  a_irq_port_gate: assert property (!PORT_IRQ_ENABLE |-> !IRQ)
    else $error("interrupt raised with port enable low");
  a_pad_bits_zero: assert property (RVALID |-> RDATA[31:16] == 16'h0 && RDATA[7:4] == 4'h0)
    else $error("read data pad bits not zero");
  a_empty_readout: assert property (s_rd_pop |=> RVALID && (RDATA[0] || RDATA == 32'h0))
    else $error("invalid readout word not all zero");
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read answer dropped early");
  a_unmapped_err: assert property (s_rd ##0 !mapped |=> RRESP == hrxf_pkg::RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (s_rd ##0 mapped |=> RRESP == hrxf_pkg::RESP_OKAY)
    else $error("mapped read refused");
  a_write_answer: assert property (s_wr_both |=> ##1 BVALID)
    else $error("write response late");
  a_full_refuse: assert property (RVALID && live_q && RDATA[hrxf_pkg::BIT_FULL] |-> !RX_WR_READY)
    else $error("receiver accepted while full");
endmodule

// File: sim/tb.sv
// Self-checking bench for the receive FIFO readout block.
// Assumes the block answers on AXI4-Lite and has a 16-entry store here.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, RX_WR_VALID;
  logic        PORT_IRQ_ENABLE, AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_WR_READY, IRQ;
  logic [7:0]  AWADDR, ARADDR, RX_WR_BYTE;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB;
  logic [2:0]  RX_WR_STATUS;
  logic [1:0]  BRESP, RRESP, r;
  logic [10:0] q[$];
  int          err_total, checked, cyc;
  localparam logic [2:0] CODES [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};

  hrxf_readout #(.DEPTH(16)) dut_u (
    .CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .RX_WR_VALID(RX_WR_VALID), .RX_WR_BYTE(RX_WR_BYTE), .RX_WR_STATUS(RX_WR_STATUS),
    .RX_WR_READY(RX_WR_READY), .PORT_IRQ_ENABLE(PORT_IRQ_ENABLE), .IRQ(IRQ)
  );

  // Expected readout word, byte mirrored when reordering is on
  function automatic logic [31:0] word(logic [7:0] b, logic [2:0] s, logic ro);
    logic [7:0] x;
    for (int k = 0; k < 8; k++)
      x[k] = ro ? b[7-k] : b[k];
    return {16'h0, x, 4'h0, s, 1'b1};
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    AWADDR <= a;
    WDATA <= v;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (AWVALID && AWREADY)
      begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge CLK); while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge CLK);
    chk(n, d, exp);
  endtask

  task automatic push(input logic [7:0] b, input logic [2:0] s);
    RX_WR_VALID <= 1'b1;
    RX_WR_BYTE <= b;
    RX_WR_STATUS <= s;
    do @(posedge CLK); while (RX_WR_READY !== 1'b1);
    RX_WR_VALID <= 1'b0;
    q.push_back({s, b});
    @(posedge CLK);
  endtask

  task automatic pop_chk(input logic ro);
    logic [10:0] v;
    v = q.pop_front();
    rdc("readout", hrxf_pkg::ADDR_READOUT, word(v[7:0], v[10:8], ro));
  endtask

  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // Hang guard
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  initial
  begin
    {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, RX_WR_VALID, PORT_IRQ_ENABLE} = '0;
    {AWADDR, ARADDR, RX_WR_BYTE, WDATA, WSTRB, RX_WR_STATUS} = '0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rdc("ctrl", hrxf_pkg::ADDR_CTRL, 32'h0000_0800);
    rdc("latch", hrxf_pkg::ADDR_LATCH, 32'h0);
    rdc("ien", hrxf_pkg::ADDR_IEN, 32'h0);
    rdc("empty", hrxf_pkg::ADDR_READOUT, 32'h0);
    rdc("unmapped", 8'h00, 32'h0);
    chk("rresp", {30'h0, r}, {30'h0, hrxf_pkg::RESP_SLVERR});
    wr(8'h04, 32'h1);
    chk("bresp", {30'h0, r}, {30'h0, hrxf_pkg::RESP_SLVERR});
    for (int i = 0; i < 6; i++)
    begin
      push(8'hB1 ^ {i[3:0], i[3:0]}, CODES[i]);
      wr(hrxf_pkg::ADDR_CTRL, {28'h0, i[0], 3'h0} | 32'h0800);
      rdc("peek", hrxf_pkg::ADDR_PEEK, word(8'hB1 ^ {i[3:0], i[3:0]}, CODES[i], i[0]));
      pop_chk(i[0]);
    end
    rdc("empty", hrxf_pkg::ADDR_READOUT, 32'h0);
    rdc("latch", hrxf_pkg::ADDR_LATCH, 32'h8);
    wr(hrxf_pkg::ADDR_CTRL, 32'h0100);
    push(8'h5A, 3'h0);
    pop_chk(1'b0);
    wr(hrxf_pkg::ADDR_LATCH, 32'hD);
    PORT_IRQ_ENABLE <= 1'b1;
    for (int i = 0; i < 7; i++)
      push(8'h30 | i[7:0], {2'b0, i == 0});
    rdc("live", hrxf_pkg::ADDR_LIVE, 32'h0);
    push(8'h37, 3'h0);
    rdc("live", hrxf_pkg::ADDR_LIVE, 32'h1);
    rdc("latch", hrxf_pkg::ADDR_LATCH, 32'h9);
    chk("irq", {31'h0, IRQ}, 32'h0);
    wr(hrxf_pkg::ADDR_IEN, 32'h8);
    chk("irq", {31'h0, IRQ}, 32'h1);
    PORT_IRQ_ENABLE <= 1'b0;
    @(posedge CLK);
    chk("irq", {31'h0, IRQ}, 32'h0);
    PORT_IRQ_ENABLE <= 1'b1;
    wr(hrxf_pkg::ADDR_LATCH, 32'h8);
    chk("irq", {31'h0, IRQ}, 32'h0);
    wr(hrxf_pkg::ADDR_IEN, 32'h1);
    chk("irq", {31'h0, IRQ}, 32'h1);
    wr(hrxf_pkg::ADDR_LATCH, 32'h1);
    chk("irq", {31'h0, IRQ}, 32'h0);
    while (RX_WR_READY === 1'b1)
      push(8'h40 | 8'(q.size()), 3'h0);
    chk("count", 32'(q.size()), 32'd16);
    rdc("live", hrxf_pkg::ADDR_LIVE, 32'h5);
    rdc("latch", hrxf_pkg::ADDR_LATCH, 32'h4);
    chk("irq", {31'h0, IRQ}, 32'h0);
    wr(hrxf_pkg::ADDR_IEN, 32'h4);
    chk("irq", {31'h0, IRQ}, 32'h1);
    while (q.size() > 0)
      pop_chk(1'b0);
    rdc("live", hrxf_pkg::ADDR_LIVE, 32'h2);
    rdc("drained", hrxf_pkg::ADDR_READOUT, 32'h0);
    stop_test();
  end
endmodule

bind hrxf_readout hrxf_readout_props props_u (
  .CLK(CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .RREADY(RREADY), .RX_WR_READY(RX_WR_READY), .PORT_IRQ_ENABLE(PORT_IRQ_ENABLE), .IRQ(IRQ)
);
